// *** shared/fvft_pkg.sv ***
// constants and types shared by the verify and format track engine
package fvft_pkg;
  // register addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_SECTOR = 4'h2;
  localparam logic [3:0] ADDR_EOT = 4'h3;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_SIZE = 4'h5;
  localparam logic [3:0] ADDR_GAP = 4'h6;
  localparam logic [3:0] ADDR_FILL = 4'h7;
  localparam logic [3:0] ADDR_SPS = 4'h8;
  localparam logic [3:0] ADDR_ID = 4'h9;
  // control register bit positions
  localparam int CTRL_VERIFY = 0;
  localparam int CTRL_FORMAT = 1;
  localparam int CTRL_MT = 2;
  localparam int CTRL_EC = 3;
  localparam int CTRL_MFM = 4;
  localparam int CTRL_PERP = 5;
  // reset values
  localparam logic [7:0] RST_SECTOR = 8'h01;
  localparam logic [7:0] RST_EOT = 8'h01;
  localparam logic [7:0] RST_COUNT = 8'hFF;
  localparam logic [7:0] RST_SPS = 8'h12;
  localparam logic [7:0] RST_GAP = 8'h1B;
  localparam logic [7:0] RST_FILL = 8'hE5;
  // byte values written on the track
  localparam logic [7:0] GAP_MFM = 8'h4E;
  localparam logic [7:0] GAP_FM = 8'hFF;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] IAM_PRE = 8'hC2;
  localparam logic [7:0] IAM_BYTE = 8'hFC;
  localparam logic [7:0] AM_PRE = 8'hA1;
  localparam logic [7:0] IDAM_BYTE = 8'hFE;
  localparam logic [7:0] DAM_BYTE = 8'hFB;
  // field lengths in bytes and the full sector count
  localparam logic [15:0] GAP4A_MFM = 16'd80;
  localparam logic [15:0] GAP4A_FM = 16'd40;
  localparam logic [15:0] SYNC_MFM = 16'd12;
  localparam logic [15:0] SYNC_FM = 16'd6;
  localparam logic [15:0] GAP1_MFM = 16'd50;
  localparam logic [15:0] GAP1_FM = 16'd26;
  localparam logic [15:0] GAP2_MFM = 16'd22;
  localparam logic [15:0] GAP2_PERP = 16'd41;
  localparam logic [15:0] GAP2_FM = 16'd11;
  localparam logic [15:0] PRE_RUN = 16'd3;
  localparam logic [15:0] ONE_BYTE = 16'd1;
  localparam logic [15:0] ID_BYTES = 16'd4;
  localparam logic [15:0] CRC_BYTES = 16'd2;
  localparam logic [15:0] BASE_SECTOR = 16'd128;
  localparam logic [15:0] MARK_MFM = 16'd4;
  localparam logic [9:0] FULL_COUNT = 10'd256;
  localparam logic [2:0] ID_FULL = 3'd4;
  // crc generator
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;

  typedef enum logic [1:0] {
    V_IDLE = 2'b00,
    V_SEEK = 2'b01,
    V_DATA = 2'b10,
    V_CHECK = 2'b11
  } fvft_vph_t;

  typedef enum logic [4:0] {
    F_IDLE = 5'b00000, F_WAITIDX = 5'b00001, F_GAP4A = 5'b00010,
    F_SYNC0 = 5'b00011, F_IAMPRE = 5'b00100, F_IAM = 5'b00101,
    F_GAP1 = 5'b00110, F_SYNC1 = 5'b00111, F_IDPRE = 5'b01000,
    F_IDMARK = 5'b01001, F_IDFLD = 5'b01010, F_IDCRC = 5'b01011,
    F_GAP2 = 5'b01100, F_SYNC2 = 5'b01101, F_DAMPRE = 5'b01110,
    F_DAM = 5'b01111, F_DATA = 5'b10000, F_DCRC = 5'b10001,
    F_GAP3 = 5'b10010, F_GAP4B = 5'b10011
  } fvft_fph_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } fvft_bus_t;

  typedef struct packed {
    logic [15:0] len;
    logic [7:0] val;
    logic mark;
  } fvft_field_t;
endpackage : fvft_pkg

// *** rtl/fvft_crc.sv ***
// byte-wide crc generator, one byte per enabled clock
`timescale 1ns/10ps
module fvft_crc (
  input wire logic clk,
  input wire logic rstn,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  typedef struct packed {
    logic [15:0] crc;
  } fvft_crc_st_t;

  fvft_crc_st_t s_r;
  fvft_crc_st_t s_nxt;
  logic [15:0] stage [0:8];

  // one shift stage per data bit, msb first
  assign stage[0] = s_r.crc;
  for (genvar gi = 0; gi < 8; gi++) begin : g_bit
    assign stage[gi + 1] = {stage[gi][14:0], 1'b0}
      ^ ((stage[gi][15] ^ data[7 - gi]) ? fvft_pkg::CRC_POLY : 16'h0000);
  end

  // preset wins over update
  always_comb begin
    s_nxt = s_r;
    if (init) begin
      s_nxt.crc = fvft_pkg::CRC_PRESET;
    end else if (en) begin
      s_nxt.crc = stage[8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{crc: fvft_pkg::CRC_PRESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign crc = s_r.crc;
endmodule : fvft_crc

// *** rtl/fvft_core.sv ***
// sector verify and track format engine of a floppy controller
// What this block does
// - verify reads sector, checks crc, no host data
// - external terminal count never ends verify
// - implicit count: end at zero, zero means 256
// - no implicit count: end after end sector
// - no implicit count: fail if end beyond side
// - implicit count: fail if count or end too big
// - multi track continues verify onto side one
// - format waits for index before writing
// - full track layout, MFM or FM
// - size, count, gap, fill shape the track
// - data field filled with host fill byte
// - format ends at the next index pulse
// - MFM preamble, marks and gap2 lengths
// - FM sync, marks and gap2 lengths, no preamble
`timescale 1ns/10ps
module fvft_core (
  input wire logic clk,
  input wire logic rstn,
  input wire fvft_pkg::fvft_bus_t bus,
  output logic [7:0] regRdData,
  input wire logic indexPulseN,
  input wire logic rdIdValid,
  input wire logic [7:0] rdIdSector,
  input wire logic rdByteValid,
  input wire logic [7:0] rdByte,
  input wire logic byteTick,
  output logic [7:0] wrByte,
  output logic wrStrobe,
  output logic wrMark,
  output logic wrGate,
  output logic headSel
);
  typedef struct packed {
    fvft_pkg::fvft_vph_t vPh;
    fvft_pkg::fvft_fph_t fPh;
    logic [15:0] cnt;
    logic [9:0] left;
    logic [7:0] sector;
    logic head;
    logic busy;
    logic done;
    logic ok;
    logic crcErr;
    logic fmtErr;
    logic idWanted;
    logic [2:0] idCnt;
    logic [31:0] idBuf;
    logic mt;
    logic ec;
    logic mfm;
    logic perp;
    logic [7:0] end_of_track_sector;
    logic [7:0] count;
    logic [2:0] size;
    logic [7:0] gap;
    logic [7:0] fill;
    logic [7:0] sps;
    logic idx1;
    logic idx2;
    logic idx3;
    logic [7:0] rdData;
    logic [7:0] wrByte;
    logic wrStrobe;
    logic wrMark;
    logic wrGate;
  } fvft_st_t;

  fvft_st_t s_r;
  fvft_st_t s_nxt;
  logic crcInit;
  logic crcEn;
  logic [7:0] crcData;
  logic [15:0] crcOut;

  fvft_crc u_crc (
    .clk(clk),
    .rstn(rstn),
    .init(crcInit),
    .en(crcEn),
    .data(crcData),
    .crc(crcOut)
  );

  // length, byte and mark flag of each track field
  function automatic fvft_pkg::fvft_field_t field(
    input fvft_pkg::fvft_fph_t p,
    input fvft_st_t s
  );
    fvft_pkg::fvft_field_t f;
    logic [7:0] g;
    g = s.mfm ? fvft_pkg::GAP_MFM : fvft_pkg::GAP_FM;
    f = '{len: fvft_pkg::ONE_BYTE, val: g, mark: 1'b0};
    case (p)
      fvft_pkg::F_GAP4A: f.len = s.mfm ? fvft_pkg::GAP4A_MFM
                                       : fvft_pkg::GAP4A_FM;
      fvft_pkg::F_GAP1: f.len = s.mfm ? fvft_pkg::GAP1_MFM
                                      : fvft_pkg::GAP1_FM;
      fvft_pkg::F_SYNC0, fvft_pkg::F_SYNC1, fvft_pkg::F_SYNC2: begin
        f.len = s.mfm ? fvft_pkg::SYNC_MFM : fvft_pkg::SYNC_FM;
        f.val = fvft_pkg::SYNC_BYTE;
      end
      fvft_pkg::F_IAMPRE: f = '{fvft_pkg::PRE_RUN, fvft_pkg::IAM_PRE, 1'b1};
      fvft_pkg::F_IDPRE, fvft_pkg::F_DAMPRE:
        f = '{fvft_pkg::PRE_RUN, fvft_pkg::AM_PRE, 1'b1};
      fvft_pkg::F_IAM: f = '{fvft_pkg::ONE_BYTE, fvft_pkg::IAM_BYTE, ~s.mfm};
      fvft_pkg::F_IDMARK:
        f = '{fvft_pkg::ONE_BYTE, fvft_pkg::IDAM_BYTE, ~s.mfm};
      fvft_pkg::F_DAM: f = '{fvft_pkg::ONE_BYTE, fvft_pkg::DAM_BYTE, ~s.mfm};
      fvft_pkg::F_IDFLD: begin
        f.len = fvft_pkg::ID_BYTES;
        f.val = s.idBuf[31:24];
      end
      fvft_pkg::F_IDCRC, fvft_pkg::F_DCRC: begin
        f.len = fvft_pkg::CRC_BYTES;
        f.val = (s.cnt == 16'h0000) ? crcOut[15:8] : crcOut[7:0];
      end
      fvft_pkg::F_GAP2: f.len = !s.mfm ? fvft_pkg::GAP2_FM :
        (s.perp ? fvft_pkg::GAP2_PERP : fvft_pkg::GAP2_MFM);
      fvft_pkg::F_DATA: begin
        f.len = fvft_pkg::BASE_SECTOR << s.size;
        f.val = s.fill;
      end
      fvft_pkg::F_GAP3: f.len = (s.gap == 8'h00) ? fvft_pkg::ONE_BYTE
                                : {8'h00, s.gap};
      default: f.len = fvft_pkg::ONE_BYTE;
    endcase
    return f;
  endfunction : field

  fvft_pkg::fvft_field_t fld;
  logic idxEdge;
  logic [9:0] scEff;
  logic [9:0] remain;
  logic wMt;
  logic wEc;
  logic preOk;
  logic [15:0] vLen;
  logic [7:0] lastOnSide;

  // next state of the whole engine
  always_comb begin
    s_nxt = s_r;
    crcInit = 1'b0;
    crcEn = 1'b0;
    crcData = rdByte;
    s_nxt.idx1 = indexPulseN;
    s_nxt.idx2 = s_r.idx1;
    s_nxt.idx3 = s_r.idx2;
    idxEdge = s_r.idx3 & ~s_r.idx2; // falling edge of the index pin
    s_nxt.rdData = 8'h00;
    s_nxt.wrStrobe = 1'b0;
    fld = field(s_r.fPh, s_r);
    wMt = bus.wrData[fvft_pkg::CTRL_MT];
    wEc = bus.wrData[fvft_pkg::CTRL_EC];
    scEff = (s_r.count == 8'h00) ? fvft_pkg::FULL_COUNT
                                 : {2'b00, s_r.count};
    remain = {2'b00, s_r.sps} - {2'b00, s_r.sector} + 10'd1
           + (wMt ? {2'b00, s_r.sps} : 10'd0);
    // precheck of the start values before any sector is read
    preOk = (s_r.end_of_track_sector <= s_r.sps)
          && (!wEc || (scEff <= remain));
    vLen = (s_r.mfm ? fvft_pkg::MARK_MFM : fvft_pkg::ONE_BYTE)
         + (fvft_pkg::BASE_SECTOR << s_r.size) + fvft_pkg::CRC_BYTES;
    lastOnSide = s_r.ec ? s_r.sps : s_r.end_of_track_sector;

    // register reads, data stand in the next cycle only
    if (bus.rd) begin
      if (bus.addr == fvft_pkg::ADDR_CTRL) begin
        s_nxt.rdData = {2'b00, s_r.perp, s_r.mfm, s_r.ec, s_r.mt, 2'b00};
      end else if (bus.addr == fvft_pkg::ADDR_STATUS) begin
        s_nxt.rdData = {1'b0, s_r.fmtErr, s_r.head, s_r.idWanted,
                        s_r.crcErr, s_r.ok, s_r.done, s_r.busy};
      end else if (bus.addr == fvft_pkg::ADDR_SECTOR) begin
        s_nxt.rdData = s_r.sector;
      end else if (bus.addr == fvft_pkg::ADDR_EOT) begin
        s_nxt.rdData = s_r.end_of_track_sector;
      end else if (bus.addr == fvft_pkg::ADDR_COUNT) begin
        s_nxt.rdData = s_r.count;
      end else if (bus.addr == fvft_pkg::ADDR_SIZE) begin
        s_nxt.rdData = {5'b00000, s_r.size};
      end else if (bus.addr == fvft_pkg::ADDR_GAP) begin
        s_nxt.rdData = s_r.gap;
      end else if (bus.addr == fvft_pkg::ADDR_FILL) begin
        s_nxt.rdData = s_r.fill;
      end else if (bus.addr == fvft_pkg::ADDR_SPS) begin
        s_nxt.rdData = s_r.sps;
      end else begin
        s_nxt.rdData = 8'h00;
      end
    end

    // register writes; parameters are held while a command runs
    if (bus.wr && !s_r.busy) begin
      if (bus.addr == fvft_pkg::ADDR_CTRL) begin
        s_nxt.mt = wMt;
        s_nxt.ec = wEc;
        s_nxt.mfm = bus.wrData[fvft_pkg::CTRL_MFM];
        s_nxt.perp = bus.wrData[fvft_pkg::CTRL_PERP];
        s_nxt.head = 1'b0;
        s_nxt.crcErr = 1'b0;
        s_nxt.fmtErr = 1'b0;
        s_nxt.ok = 1'b0;
        s_nxt.left = scEff;
        if (bus.wrData[fvft_pkg::CTRL_VERIFY]) begin
          s_nxt.done = !preOk; // invalid start ends at once
          s_nxt.busy = preOk;
          s_nxt.vPh = preOk ? fvft_pkg::V_SEEK : fvft_pkg::V_IDLE;
        end else if (bus.wrData[fvft_pkg::CTRL_FORMAT]) begin
          s_nxt.done = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.idWanted = (s_r.idCnt != fvft_pkg::ID_FULL);
          s_nxt.fPh = fvft_pkg::F_WAITIDX;
        end
      end else if (bus.addr == fvft_pkg::ADDR_SECTOR) begin
        s_nxt.sector = bus.wrData;
      end else if (bus.addr == fvft_pkg::ADDR_EOT) begin
        s_nxt.end_of_track_sector = bus.wrData;
      end else if (bus.addr == fvft_pkg::ADDR_COUNT) begin
        s_nxt.count = bus.wrData;
      end else if (bus.addr == fvft_pkg::ADDR_SIZE) begin
        s_nxt.size = bus.wrData[2:0];
      end else if (bus.addr == fvft_pkg::ADDR_GAP) begin
        s_nxt.gap = bus.wrData;
      end else if (bus.addr == fvft_pkg::ADDR_FILL) begin
        s_nxt.fill = bus.wrData;
      end else if (bus.addr == fvft_pkg::ADDR_SPS) begin
        s_nxt.sps = bus.wrData;
      end
    end
    // id bytes are taken at any time, oldest byte ends up on top
    if (bus.wr && bus.addr == fvft_pkg::ADDR_ID) begin
      s_nxt.idBuf = {s_r.idBuf[23:0], bus.wrData};
      if (s_r.idCnt != fvft_pkg::ID_FULL) begin
        s_nxt.idCnt = s_r.idCnt + 3'd1;
      end
      s_nxt.idWanted = 1'b0;
    end

    // verify engine; no terminal count input exists here
    case (s_r.vPh)
      fvft_pkg::V_SEEK: begin
        crcInit = 1'b1;
        s_nxt.cnt = 16'h0000;
        if (rdIdValid && rdIdSector == s_r.sector) begin
          s_nxt.vPh = fvft_pkg::V_DATA;
        end
      end
      fvft_pkg::V_DATA: begin
        if (rdByteValid) begin
          crcEn = 1'b1;
          s_nxt.cnt = s_r.cnt + 16'd1;
          if (s_r.cnt == vLen - 16'd1) begin
            s_nxt.vPh = fvft_pkg::V_CHECK;
          end
        end
      end
      fvft_pkg::V_CHECK: begin
        s_nxt.vPh = fvft_pkg::V_SEEK;
        s_nxt.left = s_r.left - 10'd1;
        if (crcOut != 16'h0000) begin
          s_nxt.crcErr = 1'b1;
          s_nxt.vPh = fvft_pkg::V_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else if (s_r.ec ? (s_r.left == 10'd1)
            : (s_r.sector == s_r.end_of_track_sector && (!s_r.mt || s_r.head))) begin
          s_nxt.ok = 1'b1;
          s_nxt.vPh = fvft_pkg::V_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else if (s_r.sector == lastOnSide && s_r.mt && !s_r.head) begin
          s_nxt.head = 1'b1;
          s_nxt.sector = 8'h01;
        end else begin
          s_nxt.sector = s_r.sector + 8'd1;
        end
      end
      default: ;
    endcase

    // format engine
    if (s_r.fPh == fvft_pkg::F_WAITIDX) begin
      if (idxEdge) begin
        s_nxt.fPh = fvft_pkg::F_GAP4A;
        s_nxt.cnt = 16'h0000;
        s_nxt.wrGate = 1'b1;
      end
    end else if (s_r.fPh != fvft_pkg::F_IDLE && idxEdge) begin
      s_nxt.fPh = fvft_pkg::F_IDLE;
      s_nxt.wrGate = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b1;
      s_nxt.ok = 1'b1;
    end else if (s_r.fPh != fvft_pkg::F_IDLE && byteTick) begin
      s_nxt.wrByte = fld.val;
      s_nxt.wrMark = fld.mark;
      s_nxt.wrStrobe = 1'b1;
      s_nxt.cnt = s_r.cnt + 16'd1;
      crcData = fld.val;
      crcInit = (s_r.fPh == fvft_pkg::F_SYNC1)
              || (s_r.fPh == fvft_pkg::F_SYNC2);
      crcEn = (s_r.fPh >= fvft_pkg::F_IDPRE && s_r.fPh <= fvft_pkg::F_IDFLD)
            || (s_r.fPh >= fvft_pkg::F_DAMPRE && s_r.fPh <= fvft_pkg::F_DATA);
      if (s_r.fPh == fvft_pkg::F_IDFLD) begin
        s_nxt.idBuf = {s_r.idBuf[23:0], 8'h00};
      end
      if (s_r.fPh == fvft_pkg::F_GAP4B) begin
        s_nxt.cnt = 16'h0000;
      end else if (s_r.cnt == fld.len - 16'd1) begin
        s_nxt.cnt = 16'h0000;
        case (s_r.fPh)
          fvft_pkg::F_GAP4A: s_nxt.fPh = fvft_pkg::F_SYNC0;
          fvft_pkg::F_SYNC0: s_nxt.fPh = s_r.mfm ? fvft_pkg::F_IAMPRE
                                                 : fvft_pkg::F_IAM;
          fvft_pkg::F_IAMPRE: s_nxt.fPh = fvft_pkg::F_IAM;
          fvft_pkg::F_IAM: s_nxt.fPh = fvft_pkg::F_GAP1;
          fvft_pkg::F_GAP1: s_nxt.fPh = fvft_pkg::F_SYNC1;
          fvft_pkg::F_SYNC1: begin
            if (s_r.idCnt != fvft_pkg::ID_FULL) begin
              s_nxt.fmtErr = 1'b1; // ids missing, stop writing
              s_nxt.fPh = fvft_pkg::F_IDLE;
              s_nxt.wrGate = 1'b0;
              s_nxt.busy = 1'b0;
              s_nxt.done = 1'b1;
            end else begin
              s_nxt.fPh = s_r.mfm ? fvft_pkg::F_IDPRE : fvft_pkg::F_IDMARK;
            end
          end
          fvft_pkg::F_IDPRE: s_nxt.fPh = fvft_pkg::F_IDMARK;
          fvft_pkg::F_IDMARK: s_nxt.fPh = fvft_pkg::F_IDFLD;
          fvft_pkg::F_IDFLD: begin
            s_nxt.fPh = fvft_pkg::F_IDCRC;
            s_nxt.idCnt = 3'd0;
            s_nxt.idWanted = 1'b1;
          end
          fvft_pkg::F_IDCRC: s_nxt.fPh = fvft_pkg::F_GAP2;
          fvft_pkg::F_GAP2: s_nxt.fPh = fvft_pkg::F_SYNC2;
          fvft_pkg::F_SYNC2: s_nxt.fPh = s_r.mfm ? fvft_pkg::F_DAMPRE
                                                 : fvft_pkg::F_DAM;
          fvft_pkg::F_DAMPRE: s_nxt.fPh = fvft_pkg::F_DAM;
          fvft_pkg::F_DAM: s_nxt.fPh = fvft_pkg::F_DATA;
          fvft_pkg::F_DATA: s_nxt.fPh = fvft_pkg::F_DCRC;
          fvft_pkg::F_DCRC: s_nxt.fPh = fvft_pkg::F_GAP3;
          fvft_pkg::F_GAP3: begin
            s_nxt.left = s_r.left - 10'd1;
            s_nxt.fPh = (s_r.left == 10'd1) ? fvft_pkg::F_GAP4B
                                            : fvft_pkg::F_SYNC1;
          end
          default: s_nxt.fPh = fvft_pkg::F_GAP4B;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{vPh: fvft_pkg::V_IDLE, fPh: fvft_pkg::F_IDLE,
               sector: fvft_pkg::RST_SECTOR, end_of_track_sector: fvft_pkg::RST_EOT,
               count: fvft_pkg::RST_COUNT, gap: fvft_pkg::RST_GAP,
               fill: fvft_pkg::RST_FILL, sps: fvft_pkg::RST_SPS,
               idx1: 1'b1, idx2: 1'b1, idx3: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign regRdData = s_r.rdData;
  assign wrByte = s_r.wrByte;
  assign wrStrobe = s_r.wrStrobe;
  assign wrMark = s_r.wrMark;
  assign wrGate = s_r.wrGate;
  assign headSel = s_r.head;
endmodule : fvft_core

// *** verif/fvft_core_monitor.sv ***
// assertion checker for the verify and format engine ports
`timescale 1ns/10ps
module fvft_core_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire fvft_pkg::fvft_bus_t bus,
  input wire logic [7:0] regRdData,
  input wire logic indexPulseN,
  input wire logic byteTick,
  input wire logic [7:0] wrByte,
  input wire logic wrStrobe,
  input wire logic wrMark,
  input wire logic wrGate
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // serializer asks for a byte while the track is written
  sequence s_tick;
    byteTick && wrGate;
  endsequence
  // index edge arriving while the gate is open
  sequence s_idx_end;
    wrGate && $fell(indexPulseN);
  endsequence
  property p_strobe_resp;
    s_tick |=> wrStrobe;
  endproperty
  a_strobe_resp: assert property (p_strobe_resp)
    else $error("no strobe after tick");
  property p_strobe_cause;
    wrStrobe |-> $past(byteTick) ##1 !wrStrobe;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("strobe without tick");
  property p_rd_idle;
    regRdData != 8'h00 |-> $past(bus.rd);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside answer");
  property p_gate_idx;
    $rose(wrGate) |-> !$past(indexPulseN, 2);
  endproperty
  a_gate_idx: assert property (p_gate_idx)
    else $error("gate opened without index");
  property p_gate_end;
    s_idx_end |-> ##[2:6] !wrGate;
  endproperty
  a_gate_end: assert property (p_gate_end)
    else $error("gate open after index");
  property p_mark;
    wrStrobe && wrMark |-> wrByte inside {8'hC2, 8'hA1, 8'hFC, 8'hFE, 8'hFB};
  endproperty
  a_mark: assert property (p_mark)
    else $error("mark flag on plain byte");
  property p_no_write;
    !wrGate && !$past(wrGate) |-> !wrStrobe;
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("write strobe with gate closed");
  property p_byte_hold;
    wrGate && $past(wrGate) && !wrStrobe |-> $stable(wrByte) && $stable(wrMark);
  endproperty
  a_byte_hold: assert property (p_byte_hold)
    else $error("write byte moved between strobes");
endmodule : fvft_core_monitor

bind fvft_core fvft_core_monitor MON (.clk(clk), .rstn(rstn), .bus(bus),
  .regRdData(regRdData), .indexPulseN(indexPulseN), .byteTick(byteTick),
  .wrByte(wrByte), .wrStrobe(wrStrobe), .wrMark(wrMark), .wrGate(wrGate));

// *** verif/fvft_drive_model.sv ***
// drive model: index pin, read stream and write serializer
`timescale 1ns/10ps
module fvft_drive_model (
  input wire logic clk,
  input wire logic wrGate,
  input wire logic wrStrobe,
  input wire logic wrMark,
  input wire logic [7:0] wrByte,
  output logic indexPulseN,
  output logic byteTick,
  output logic rdIdValid,
  output logic [7:0] rdIdSector,
  output logic rdByteValid,
  output logic [7:0] rdByte
);
  logic [8:0] capQ[$];
  logic [1:0] tickCnt = 2'h0;
  logic tickR = 1'b0;
  assign byteTick = tickR;
  initial begin
    indexPulseN = 1'b1;
    rdIdValid = 1'b0;
    rdIdSector = 8'h00;
    rdByteValid = 1'b0;
    rdByte = 8'h00;
  end
  // ticks stop one clock after the index pin drops, captures each written byte
  always @(posedge clk) begin
    tickCnt <= tickCnt + 2'h1;
    tickR <= wrGate && indexPulseN && (tickCnt == 2'h0);
    if (wrStrobe) capQ.push_back({wrMark, wrByte});
  end
  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int k = 7; k >= 0; k--) begin
      c = (c[15] ^ d[k]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crcStep
  task automatic idx();
    @(posedge clk);
    indexPulseN <= 1'b0;
    repeat (12) @(posedge clk);
    indexPulseN <= 1'b1;
  endtask : idx
  // one mfm sector of size code 0: id, mark, 128 data, crc; bad spoils crc
  task automatic sendSector(input logic [7:0] sec, input logic bad);
    logic [15:0] c;
    logic [7:0] b;
    c = 16'hFFFF;
    @(posedge clk);
    rdIdValid <= 1'b1;
    rdIdSector <= sec;
    @(posedge clk);
    rdIdValid <= 1'b0;
    rdIdSector <= ~sec;
    for (int i = 0; i < 134; i++) begin
      b = (i < 3) ? 8'hA1 : (i == 3) ? 8'hFB : i[7:0];
      if (i == 132) b = c[15:8] ^ {7'h00, bad};
      if (i == 133) b = c[7:0];
      if (i < 132) c = crcStep(c, b);
      rdByte <= b;
      rdByteValid <= 1'b1;
      @(posedge clk);
      rdByteValid <= 1'b0;
      rdByte <= ~b;
      @(posedge clk);
    end
  endtask : sendSector
endmodule : fvft_drive_model

// *** verif/fvft_core_tb.sv ***
// self-checking bench for the verify and format engine
`timescale 1ns/10ps
module fvft_core_tb;
  logic clk;
  logic rstn;
  fvft_pkg::fvft_bus_t bus;
  logic [7:0] regRdData, rdIdSector, rdByte, wrByte;
  logic indexPulseN, rdIdValid, rdByteValid, byteTick;
  logic wrStrobe, wrMark, wrGate, headSel;
  logic [7:0] st;
  logic [9:0] exQ[$];
  int nErrors = 0;
  int samplesChecked = 0;
  fvft_core DUT (.clk(clk), .rstn(rstn), .bus(bus), .regRdData(regRdData),
    .indexPulseN(indexPulseN), .rdIdValid(rdIdValid),
    .rdIdSector(rdIdSector), .rdByteValid(rdByteValid), .rdByte(rdByte),
    .byteTick(byteTick), .wrByte(wrByte), .wrStrobe(wrStrobe),
    .wrMark(wrMark), .wrGate(wrGate), .headSel(headSel));
  fvft_drive_model DRV (.clk(clk), .wrGate(wrGate), .wrStrobe(wrStrobe),
    .wrMark(wrMark), .wrByte(wrByte), .indexPulseN(indexPulseN),
    .byteTick(byteTick), .rdIdValid(rdIdValid), .rdIdSector(rdIdSector),
    .rdByteValid(rdByteValid), .rdByte(rdByte));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= {a, d, 2'b00};
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clk);
    bus <= {a, 8'h00, 2'b00};
    @(negedge clk);
    v = regRdData;
  endtask : rd
  // poll status until done, bounded
  task automatic waitDone();
    for (int i = 0; i < 4000; i++) begin
      rd(fvft_pkg::ADDR_STATUS, st);
      if (st[1] === 1'b1) break;
    end
  endtask : waitDone
  task automatic addx(input int n, input logic [9:0] e);
    repeat (n) exQ.push_back(e);
  endtask : addx
  // reset values of every register and an unmapped address
  task automatic t_reset();
    logic [7:0] v;
    logic [7:0] ex[10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00,
                           8'h1B, 8'hE5, 8'h12, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd((i == 9) ? 4'hF : i[3:0], v);
      chk("reset reg", ex[i], v);
    end
  endtask : t_reset
  // implicit count of two with a foreign sector first, then a crc fault
  task automatic t_ver_ec();
    wr(4'h2, 8'h03);
    wr(4'h4, 8'h02);
    wr(4'h0, 8'h19);
    DRV.sendSector(8'h07, 1'b0);
    DRV.sendSector(8'h03, 1'b0);
    DRV.sendSector(8'h04, 1'b0);
    waitDone();
    chk("count status", 8'h06, st);
    wr(4'h2, 8'h05);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h19);
    DRV.sendSector(8'h05, 1'b1);
    waitDone();
    chk("crc status", 8'h0A, st);
  endtask : t_ver_ec
  // end sector ends verify; end sector past the side or count too big fail
  task automatic t_ver_eot();
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h02);
    wr(4'h4, 8'hFF);
    wr(4'h0, 8'h11);
    DRV.sendSector(8'h01, 1'b0);
    rd(fvft_pkg::ADDR_STATUS, st);
    chk("mid status", 8'h01, st);
    DRV.sendSector(8'h02, 1'b0);
    waitDone();
    chk("eot status", 8'h06, st);
    wr(4'h3, 8'h13);
    wr(4'h0, 8'h11);
    waitDone();
    chk("eot fail", 8'h02, st);
    wr(4'h3, 8'h12);
    wr(4'h4, 8'h13);
    wr(4'h0, 8'h19);
    waitDone();
    chk("count fail", 8'h02, st);
  endtask : t_ver_eot
  // multi track with two sectors a side carries on to side one
  task automatic t_mt();
    wr(4'h8, 8'h02);
    wr(4'h2, 8'h02);
    wr(4'h3, 8'h02);
    wr(4'h4, 8'h02);
    wr(4'h0, 8'h1D);
    DRV.sendSector(8'h02, 1'b0);
    repeat (3) @(posedge clk);
    chk("headSel", 8'h01, {7'h00, headSel});
    DRV.sendSector(8'h01, 1'b0);
    waitDone();
    chk("mt status", 8'h26, st);
  endtask : t_mt
  // one mfm sector; compares the written stream byte by byte
  task automatic t_format();
    logic [15:0] c;
    wr(4'h4, 8'h01);
    wr(4'h6, 8'h05);
    wr(4'h7, 8'hA5);
    wr(4'h9, 8'h10);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h07);
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h12);
    repeat (20) @(posedge clk);
    chk("gate before index", 8'h00, {7'h00, wrGate});
    DRV.idx();
    addx(80, 10'h04E);
    addx(12, 10'h000);
    addx(3, 10'h1C2);
    addx(1, 10'h0FC);
    addx(50, 10'h04E);
    addx(12, 10'h000);
    addx(3, 10'h1A1);
    addx(1, 10'h0FE);
    addx(1, 10'h010);
    addx(1, 10'h000);
    addx(1, 10'h007);
    addx(1, 10'h000);
    addx(2, 10'h200);
    addx(22, 10'h04E);
    addx(12, 10'h000);
    addx(3, 10'h1A1);
    addx(1, 10'h0FB);
    addx(128, 10'h0A5);
    addx(2, 10'h200);
    addx(13, 10'h04E);
    for (int i = 0; i < 3000 && DRV.capQ.size() < exQ.size(); i++)
      @(posedge clk);
    for (int i = 0; i < exQ.size(); i++) begin
      if (exQ[i][9] === 1'b0) begin
        chk("wrByte", exQ[i][7:0], DRV.capQ[i][7:0]);
        chk("wrMark", {7'h00, exQ[i][8]}, {7'h00, DRV.capQ[i][8]});
      end
    end
    // residue over id field and data field, mark bytes through crc
    c = 16'hFFFF;
    for (int i = 158; i < 336; i++) begin
      c = DRV.crcStep((i == 202) ? 16'hFFFF : c, DRV.capQ[i][7:0]);
      if (i == 167 || i == 335) chk("crc", 8'h00, c[15:8] | c[7:0]);
    end
    DRV.idx();
    waitDone();
    chk("format status", 8'h06, {4'h0, st[3:0]});
    chk("gate after index", 8'h00, {7'h00, wrGate});
  endtask : t_format
  // fm track with fresh ids: bytes and marks at the field borders
  task automatic t_fm();
    int ix[8] = '{39, 40, 46, 72, 73, 79, 96, 97};
    logic [8:0] ex[8] = '{9'h0FF, 9'h000, 9'h1FC, 9'h0FF, 9'h000, 9'h1FE,
                          9'h0FF, 9'h000};
    repeat (4) wr(4'h9, 8'h01);
    DRV.capQ.delete();
    wr(4'h0, 8'h02);
    DRV.idx();
    for (int i = 0; i < 2000 && DRV.capQ.size() < 98; i++) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      chk("fm byte", ex[i][7:0], DRV.capQ[ix[i]][7:0]);
      chk("fm mark", {7'h00, ex[i][8]}, {7'h00, DRV.capQ[ix[i]][8]});
    end
  endtask : t_fm
  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // scenarios need some 4200 cycles; 60000 means a hang
  initial begin
    #300000;
    nErrors++;
    summarize();
  end
  // reset, then the scenarios in turn
  initial begin
    rstn = 1'b0;
    bus = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_ver_ec();
    t_ver_eot();
    t_mt();
    t_format();
    t_fm();
    summarize();
  end
endmodule : fvft_core_tb
